// *** verilog/cdw_consts.svh ***
// Purpose: offsets, field positions, reset values for the descriptor walker
// Assumes: table laid out as a 16-byte header, then 16-byte descriptors
// Notes:   included by bare name; definitions only
`ifndef CDW_CONSTS_SVH
`define CDW_CONSTS_SVH

// byte offsets inside the host-resident table
`define CDW_HDR_STATUS_OFS  64'h0000_0000_0000_000C
`define CDW_DESC0_OFS       64'h0000_0000_0000_0010
`define CDW_DWORD_STEP      64'h0000_0000_0000_0004

// fields of descriptor dword 0
`define CDW_LEN_MSB         15
`define CDW_LEN_LSB         0
`define CDW_WB_BIT          17
`define CDW_IRQ_BIT         16

// dword positions inside one descriptor
`define CDW_DW_CTRL         2'h0
`define CDW_DW_EP_ADDR      2'h1
`define CDW_DW_HOST_HI      2'h2
`define CDW_DW_HOST_LO      2'h3

// reset values
`define CDW_RST_INDEX       16'h0000
`define CDW_RST_ADDR        64'h0000_0000_0000_0000
`define CDW_RST_WORD        32'h0000_0000

`endif

// *** verilog/cdw_pkg.sv ***
// Purpose: types shared by the descriptor walker and its users
// Assumes: dword lengths fit in 16 bits
// Notes:   fields of one launched transfer travel together
package cdw_pkg;

    // one transfer handed to the data mover
    typedef struct packed {
        logic [15:0] len_dw;
        logic [31:0] ep_addr;
        logic [63:0] host_addr;
    } cdw_xfer_type;

    // one-hot walker states
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_FETCH  = 7'h02,
        ST_LAUNCH = 7'h04,
        ST_RUN    = 7'h08,
        ST_WB     = 7'h10,
        ST_IRQ    = 7'h20,
        ST_NEXT   = 7'h40
    } cdw_state_type;

endpackage

// *** verilog/cdw_walker.sv ***
// Purpose: walks a host-resident descriptor table, launching one transfer per descriptor
// Assumes: all inputs come from logic on CLK_SYS; host reads answer one dword at a time
// Notes:   status writeback and completion interrupt are requests held until acknowledged
//
// How it works
// - fetch descriptors one after another from host
// - one transfer launched per processed descriptor
// - progress written to header dword at 0xC
// - written value is zero-based last completed index
// - dword 0: length low, flags 21:16
// - length counts 32-bit dwords, not bytes
// - bit 17 writeback enable, bit 16 interrupt
// - dword 1 is 32-bit endpoint address
// - host address: dword 2 upper, dword 3 lower
// - writeback if descriptor bit or control bit
// - when enabled, write finished index to table
// - interrupt if descriptor bit or header bit
// - send interrupt after the descriptor's transfer completes
// - last completed index shown on status port
`timescale 1ns/1ps
`include "cdw_consts.svh"

module cdw_walker #(
    parameter int IDX_W = 16
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RESET,
    // run control
    input  wire logic                 START,
    input  wire logic [63:0]          TABLE_BASE,
    input  wire logic [IDX_W-1:0]     LAST_INDEX,
    input  wire logic                 CTRL_WB_ENABLE,
    input  wire logic                 HDR_IRQ_ENABLE,
    // descriptor reads from host memory
    output logic                      RD_REQ,
    output logic [63:0]               RD_ADDR,
    input  wire logic                 RD_VALID,
    input  wire logic [31:0]          RD_DATA,
    // transfer launch to the data mover
    output logic                      XFER_REQ,
    output cdw_pkg::cdw_xfer_type     XFER_CMD,
    input  wire logic                 XFER_DONE,
    // status writeback into the table header
    output logic                      WB_REQ,
    output logic [63:0]               WB_ADDR,
    output logic [31:0]               WB_DATA,
    input  wire logic                 WB_ACK,
    // completion interrupt
    output logic                      MSI_REQ,
    input  wire logic                 MSI_ACK,
    // status
    output logic                      BUSY,
    output logic                      DESC_EMPTY,
    output logic [IDX_W-1:0]          LAST_DONE_INDEX
);
    import cdw_pkg::*;

    cdw_state_type    state;
    cdw_state_type    next_state;
    logic [63:0]      table_base;
    logic [IDX_W-1:0] last_index;
    logic [IDX_W-1:0] cur_index;
    logic [1:0]       dw_sel;
    logic [31:0]      desc_word [0:3];
    logic             ctrl_wb;
    logic             hdr_irq;

    // decoded descriptor fields and handshake terms
    wire logic        rd_take;
    wire logic        last_dword;
    wire logic        done_writeback_enable;
    wire logic        completion_irq_enable;
    wire logic        list_end;
    wire logic [63:0] first_desc_addr;
    wire logic [63:0] status_addr;
    wire logic [31:0] status_word;
    wire cdw_xfer_type decoded_xfer;
    wire logic        start_take;
    wire logic        xfer_end;
    wire logic        wb_enter;
    wire logic        irq_enter;
    wire logic        step_next;
    wire logic        walk_end;
    wire logic        refetch;

    // a data beat only counts while a read is outstanding
    assign rd_take         = RD_REQ & RD_VALID;
    assign last_dword      = (dw_sel == `CDW_DW_HOST_LO);
    assign list_end        = (cur_index == last_index);
    assign first_desc_addr = TABLE_BASE + `CDW_DESC0_OFS;
    assign status_addr     = table_base + `CDW_HDR_STATUS_OFS;
    assign status_word     = {{(32-IDX_W){1'b0}}, cur_index};

    // state-qualified events, named once so the register processes stay short
    assign start_take = (state == ST_IDLE) && START;
    assign xfer_end   = (state == ST_RUN) && XFER_DONE;
    assign wb_enter   = xfer_end && done_writeback_enable;
    assign irq_enter  = (next_state == ST_IRQ) && (state != ST_IRQ);
    assign step_next  = (state == ST_NEXT) && !list_end;
    assign walk_end   = (state == ST_NEXT) && list_end;
    assign refetch    = (state == ST_FETCH) && !RD_REQ;

    // per-descriptor flags ORed with the run-wide control bits
    assign done_writeback_enable = desc_word[`CDW_DW_CTRL][`CDW_WB_BIT] | ctrl_wb;
    assign completion_irq_enable = desc_word[`CDW_DW_CTRL][`CDW_IRQ_BIT] | hdr_irq;

    // reserved bits 31:22 and 21:18 are ignored, never acted on
    assign decoded_xfer.len_dw    = desc_word[`CDW_DW_CTRL][`CDW_LEN_MSB:`CDW_LEN_LSB];
    assign decoded_xfer.ep_addr   = desc_word[`CDW_DW_EP_ADDR];
    assign decoded_xfer.host_addr = {desc_word[`CDW_DW_HOST_HI],
                                     desc_word[`CDW_DW_HOST_LO]};

    // state sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                // a start while busy is dropped without trace; wait for BUSY low
                if (START) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (rd_take && last_dword) begin
                    next_state = ST_LAUNCH;
                end
            end
            ST_LAUNCH: begin
                next_state = ST_RUN;
            end
            ST_RUN: begin
                // a done pulse seen in any other state is ignored, so it cannot skip a descriptor
                if (XFER_DONE) begin
                    if (done_writeback_enable) begin
                        next_state = ST_WB;
                    end else if (completion_irq_enable) begin
                        next_state = ST_IRQ;
                    end else begin
                        next_state = ST_NEXT;
                    end
                end
            end
            ST_WB: begin
                if (WB_ACK) begin
                    next_state = completion_irq_enable ? ST_IRQ : ST_NEXT;
                end
            end
            ST_IRQ: begin
                if (MSI_ACK) begin
                    next_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                next_state = list_end ? ST_IDLE : ST_FETCH;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // run parameters latched at start; they hold for the whole list
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            table_base <= `CDW_RST_ADDR;
            last_index <= IDX_W'(0);
            ctrl_wb    <= 1'b0;
            hdr_irq    <= 1'b0;
        end else if (start_take) begin
            table_base <= TABLE_BASE;
            last_index <= LAST_INDEX;
            ctrl_wb    <= CTRL_WB_ENABLE;
            hdr_irq    <= HDR_IRQ_ENABLE;
        end
    end

    // descriptor words captured as they arrive; the table is never written here
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_word
            always_ff @(posedge CLK_SYS) begin
                if (RESET) begin
                    desc_word[gi] <= `CDW_RST_WORD;
                end else if (rd_take && dw_sel == 2'(gi)) begin
                    desc_word[gi] <= RD_DATA;
                end
            end
        end
    endgenerate

    // descriptor read port: one dword per request, address walks upward
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            RD_REQ  <= 1'b0;
            RD_ADDR <= `CDW_RST_ADDR;
            dw_sel  <= 2'h0;
        end else if (start_take) begin
            RD_REQ  <= 1'b1;
            RD_ADDR <= first_desc_addr;
            dw_sel  <= 2'h0;
        end else if (rd_take) begin
            // drop request for a cycle so the next address is never confused with the old answer
            RD_REQ  <= 1'b0;
            RD_ADDR <= RD_ADDR + `CDW_DWORD_STEP;
            dw_sel  <= dw_sel + 2'h1;
        end else if (refetch) begin
            RD_REQ  <= 1'b1;
        end else if (step_next) begin
            RD_REQ  <= 1'b1;
        end
    end

    // descriptor index: ascending, one step per finished descriptor
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cur_index <= IDX_W'(0);
        end else if (start_take) begin
            cur_index <= IDX_W'(0);
        end else if (step_next) begin
            cur_index <= cur_index + IDX_W'(1);
        end
    end

    // transfer launch: one-cycle strobe with the decoded command
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            XFER_REQ <= 1'b0;
            XFER_CMD <= '0;
        end else begin
            XFER_REQ <= (state == ST_LAUNCH);
            if (state == ST_LAUNCH) begin
                XFER_CMD <= decoded_xfer;
            end
        end
    end

    // completed index, visible on the status port even without writeback
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            LAST_DONE_INDEX <= IDX_W'(`CDW_RST_INDEX);
        end else if (xfer_end) begin
            LAST_DONE_INDEX <= cur_index;
        end
    end

    // status writeback into the header, held until taken
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            WB_REQ  <= 1'b0;
            WB_ADDR <= `CDW_RST_ADDR;
            WB_DATA <= `CDW_RST_WORD;
        end else if (wb_enter) begin
            WB_REQ  <= 1'b1;
            WB_ADDR <= status_addr;
            WB_DATA <= status_word;
        end else if (WB_ACK) begin
            WB_REQ  <= 1'b0;
        end
    end

    // completion interrupt, raised only after the transfer and any writeback
    // the message never overtakes the status write, so the host reads a settled index
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            MSI_REQ <= 1'b0;
        end else if (irq_enter) begin
            MSI_REQ <= 1'b1;
        end else if (MSI_ACK) begin
            MSI_REQ <= 1'b0;
        end
    end

    // run status
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            BUSY       <= 1'b0;
            DESC_EMPTY <= 1'b1;
        end else if (start_take) begin
            BUSY       <= 1'b1;
            DESC_EMPTY <= 1'b0;
        end else if (walk_end) begin
            BUSY       <= 1'b0;
            DESC_EMPTY <= 1'b1;
        end
    end

    // the host keeps the table within one 4 KByte page the walker does not check it
    // so a table crossing a page boundary is simply read at the linear addresses
    // a reset in mid-walk abandons the list silently; the header status keeps whatever
    // index was last written, so the host must clear it before starting again

endmodule

// *** dv/cdw_walker_checker.sv ***
// Purpose: port-level checks for the descriptor walker
// Assumes: one clock, synchronous active-high reset
// Notes:   table base stays put while a walk runs
`timescale 1ns/1ps
module cdw_walker_checker #(
    parameter int IDX_W = 16
) (
    input wire logic             CLK_SYS,
    input wire logic             RESET,
    input wire logic             START,
    input wire logic [63:0]      TABLE_BASE,
    input wire logic             RD_REQ,
    input wire logic [63:0]      RD_ADDR,
    input wire logic             RD_VALID,
    input wire logic             XFER_REQ,
    input wire logic             WB_REQ,
    input wire logic [63:0]      WB_ADDR,
    input wire logic [31:0]      WB_DATA,
    input wire logic             WB_ACK,
    input wire logic             MSI_REQ,
    input wire logic             MSI_ACK,
    input wire logic             BUSY,
    input wire logic             DESC_EMPTY,
    input wire logic [IDX_W-1:0] LAST_DONE_INDEX
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // a walk starts at descriptor zero, just past the header
    start_fetch_a: assert property (START && !BUSY
        |=> BUSY && RD_REQ && RD_ADDR == $past(TABLE_BASE) + 64'h10)
        else $error("walk did not start at descriptor zero");
    rd_hold_a: assert property (RD_REQ && !RD_VALID |=> RD_REQ && $stable(RD_ADDR))
        else $error("read request not held");
    // dwords of one descriptor come in rising order, 4 bytes apart
    rd_step_a: assert property (RD_REQ && RD_VALID && RD_ADDR[3:0] != 4'hC
        |=> !RD_REQ && RD_ADDR == $past(RD_ADDR) + 64'h4 ##1 RD_REQ)
        else $error("bad dword step");
    launch_after_a: assert property (RD_REQ && RD_VALID && RD_ADDR[3:0] == 4'hC |-> ##2 XFER_REQ)
        else $error("no launch after last dword");
    xfer_alone_a: assert property (XFER_REQ |-> !RD_REQ && !WB_REQ && !MSI_REQ ##1 !XFER_REQ)
        else $error("launch overlaps other traffic");
    wb_field_a: assert property (WB_REQ
        |-> WB_ADDR == TABLE_BASE + 64'hC && WB_DATA == 32'(LAST_DONE_INDEX))
        else $error("bad status writeback");
    wb_hold_a: assert property (WB_REQ && !WB_ACK |=> WB_REQ && $stable(WB_DATA))
        else $error("writeback not held");
    msi_hold_a: assert property (MSI_REQ && !MSI_ACK |=> MSI_REQ)
        else $error("interrupt not held");
    wb_first_a: assert property (WB_REQ |-> !MSI_REQ)
        else $error("interrupt before writeback");
    empty_flag_a: assert property (DESC_EMPTY == !BUSY)
        else $error("empty flag disagrees with busy");
    // completions count upward by one within a walk, or restart from zero
    idx_ascend_a: assert property ($changed(LAST_DONE_INDEX)
        |-> LAST_DONE_INDEX == $past(LAST_DONE_INDEX) + 1'b1 || LAST_DONE_INDEX == '0)
        else $error("completed index out of order");
    // a walk ends only with no request of any kind left open
    end_quiet_a: assert property ($rose(DESC_EMPTY) |-> !RD_REQ && !WB_REQ && !MSI_REQ)
        else $error("walk ended with traffic open");
    cover property (XFER_REQ);
    cover property (WB_REQ && WB_ACK);
    cover property (MSI_REQ && MSI_ACK);
    cover property ($fell(BUSY));
endmodule
bind cdw_walker cdw_walker_checker #(.IDX_W(IDX_W)) i_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .START(START),
    .TABLE_BASE(TABLE_BASE), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_VALID(RD_VALID), .XFER_REQ(XFER_REQ),
    .WB_REQ(WB_REQ), .WB_ADDR(WB_ADDR), .WB_DATA(WB_DATA), .WB_ACK(WB_ACK), .MSI_REQ(MSI_REQ),
    .MSI_ACK(MSI_ACK), .BUSY(BUSY), .DESC_EMPTY(DESC_EMPTY), .LAST_DONE_INDEX(LAST_DONE_INDEX));

// *** dv/cdw_host_model.sv ***
// Purpose: host memory and data mover answering the walker
// Assumes: table base aligned to 256 bytes, so address bits 7:2 index it
// Notes:   slow mode answers about one cycle in four
`timescale 1ns/1ps
module cdw_host_model (
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic        FAST,
    input wire logic        RD_REQ,
    input wire logic [63:0] RD_ADDR,
    output logic            RD_VALID,
    output logic [31:0]     RD_DATA,
    input wire logic        XFER_REQ,
    output logic            XFER_DONE,
    input wire logic        WB_REQ,
    input wire logic [63:0] WB_ADDR,
    input wire logic [31:0] WB_DATA,
    output logic            WB_ACK,
    output logic            MSI_REQ_SEEN,
    input wire logic        MSI_REQ,
    output logic            MSI_ACK
);
    logic [31:0] mem [0:63]; // header at 0, descriptors from 0x10
    logic        pend;
    logic        go;
    logic        hit;
    assign MSI_REQ_SEEN = MSI_REQ;
    // idle read data toggles so a stale value never looks valid
    always @(posedge CLK_SYS) begin
        go = FAST || ($urandom % 4 == 0);
        hit = RD_REQ && !RD_VALID && go;
        if (RESET) begin
            {RD_VALID, WB_ACK, MSI_ACK, XFER_DONE, pend} <= 5'h00;
            RD_DATA <= 32'h0000_0000;
        end else begin
            RD_VALID <= hit;
            RD_DATA <= hit ? mem[RD_ADDR[7:2]] : ~RD_DATA;
            WB_ACK <= WB_REQ && !WB_ACK && go;
            if (WB_REQ && WB_ACK) mem[WB_ADDR[7:2]] <= WB_DATA;
            MSI_ACK <= MSI_REQ && !MSI_ACK && go;
            pend <= (pend || XFER_REQ) && !XFER_DONE;
            XFER_DONE <= pend && !XFER_DONE && go;
        end
    end
endmodule

// *** dv/testbench.sv ***
// Purpose: random descriptor lists walked and compared with a bench model
// Assumes: host model answers fast or slow as told
// Notes:   a second start is thrown at every walk except the one cut short by reset
`timescale 1ns/1ps
module testbench;
    import cdw_pkg::*;
    logic CLK_SYS = 0, RESET = 1, START = 0, CTRL_WB_ENABLE = 0, HDR_IRQ_ENABLE = 0, fast = 0;
    logic [63:0] TABLE_BASE = '0, RD_ADDR, WB_ADDR;
    logic [15:0] LAST_INDEX = '0, LAST_DONE_INDEX;
    logic [31:0] RD_DATA, WB_DATA;
    logic RD_REQ, RD_VALID, XFER_REQ, XFER_DONE, WB_REQ, WB_ACK, MSI_REQ, MSI_ACK, BUSY, DESC_EMPTY;
    cdw_xfer_type XFER_CMD, cmd_q[$];
    int n_mismatch = 0, check_count = 0, wb_q[$], msi_q[$];
    always #50 CLK_SYS = ~CLK_SYS;
    cdw_walker i_dut (.CLK_SYS, .RESET, .START, .TABLE_BASE, .LAST_INDEX, .CTRL_WB_ENABLE, .HDR_IRQ_ENABLE,
        .RD_REQ, .RD_ADDR, .RD_VALID, .RD_DATA, .XFER_REQ, .XFER_CMD, .XFER_DONE, .WB_REQ, .WB_ADDR,
        .WB_DATA, .WB_ACK, .MSI_REQ, .MSI_ACK, .BUSY, .DESC_EMPTY, .LAST_DONE_INDEX);
    cdw_host_model i_host (.CLK_SYS, .RESET, .FAST(fast), .RD_REQ, .RD_ADDR, .RD_VALID, .RD_DATA, .XFER_REQ,
        .XFER_DONE, .WB_REQ, .WB_ADDR, .WB_DATA, .WB_ACK, .MSI_REQ_SEEN(), .MSI_REQ, .MSI_ACK);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // every launch, writeback and interrupt is matched against the queues
    always @(posedge CLK_SYS) begin
        if (!RESET && XFER_REQ === 1'b1) check(XFER_CMD, cmd_q.pop_front());
        if (!RESET && WB_REQ === 1'b1 && WB_ACK === 1'b1) check(WB_DATA, wb_q.pop_front());
        if (!RESET && MSI_REQ === 1'b1 && MSI_ACK === 1'b1) check(LAST_DONE_INDEX, msi_q.pop_front());
    end
    task automatic run(input int n, input bit f);
        logic [31:0] d0;
        logic [63:0] base;
        logic cw, hi;
        int last_wb;
        cdw_xfer_type c;
        base = {$urandom, $urandom} & 64'hFFFF_FFFF_FFFF_FF00; // one 4 KByte page
        cw = 1'($urandom);
        hi = 1'($urandom);
        last_wb = -1;
        i_host.mem[3] = 32'hFFFF_FFFF;
        // reserved bits stay random, they must not matter
        for (int i = 0; i < n; i++) begin
            d0 = $urandom;
            c = {d0[15:0], $urandom, $urandom, $urandom};
            i_host.mem[4+4*i] = d0;
            i_host.mem[5+4*i] = c.ep_addr;
            {i_host.mem[6+4*i], i_host.mem[7+4*i]} = c.host_addr;
            cmd_q.push_back(c);
            if (d0[17] || cw) wb_q.push_back(i);
            if (d0[17] || cw) last_wb = i;
            if (d0[16] || hi) msi_q.push_back(i);
        end
        @(posedge CLK_SYS);
        fast <= f;
        TABLE_BASE <= base;
        LAST_INDEX <= 16'(n - 1);
        CTRL_WB_ENABLE <= cw;
        HDR_IRQ_ENABLE <= hi;
        START <= 1'b1;
        @(posedge CLK_SYS);
        START <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        // a start during a walk is ignored
        START <= 1'b1;
        LAST_INDEX <= 16'h0000;
        @(posedge CLK_SYS);
        START <= 1'b0;
        for (int k = 0; k < 20000 && BUSY !== 1'b0; k++) @(posedge CLK_SYS);
        check(cmd_q.size() + wb_q.size() + msi_q.size(), 0);
        check(LAST_DONE_INDEX, n - 1);
        check(DESC_EMPTY, 1'b1);
        check(i_host.mem[3], last_wb < 0 ? 32'hFFFF_FFFF : 32'(last_wb));
    endtask
    initial begin
        void'($urandom(32'h85FF8A8E));
        repeat (20) @(posedge CLK_SYS);
        RESET <= 1'b0;
        run(1, 1'b1);
        run(15, 1'b0);
        // a reset in mid-walk, before any launch, returns every output to rest
        @(posedge CLK_SYS);
        LAST_INDEX <= 16'h0003;
        START <= 1'b1;
        @(posedge CLK_SYS);
        START <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        check(BUSY, 1'b1);
        RESET <= 1'b1;
        @(posedge CLK_SYS);
        RESET <= 1'b0;
        @(posedge CLK_SYS);
        check({BUSY, DESC_EMPTY, RD_REQ, XFER_REQ, WB_REQ, MSI_REQ, LAST_DONE_INDEX}, {6'h10, 16'h0000});
        check(RD_ADDR, 64'h0000_0000_0000_0000);
        check(XFER_CMD, 112'h0);
        for (int j = 0; j < 10; j++) run(1 + $urandom % 4, 1'(j));
        end_sim;
    end
    // watchdog sized well past the slowest expected walks
    initial begin
        #5000000;
        n_mismatch++;
        end_sim;
    end
endmodule
